/* src/ipsc_pkg.sv */
package ipsc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 28;             // Byte address width
  localparam int DATA_W = 16;             // Register width
  localparam int LVL_W  = 4;              // Priority field width
  localparam int NUM_EXT = 8;             // External request inputs
  localparam int NUM_SRC = 9;             // Arbitrated on-chip sources
  localparam int SRC_W  = 4;              // Source index width

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [27:0] OFS_PRIO_TMR_SER  = 28'h5ffff8a; // Timer/serial
  localparam logic [27:0] OFS_PRIO_SER_2ND  = 28'h5ffff8c; // Second serial
  localparam logic [27:0] OFS_SENSE_CTRL    = 28'h5ffff8e; // Sense control

  // ----------------------------------------------------------------
  // Field positions (low bit of each 4-bit field, bit index of each one-bit flag)
  // ----------------------------------------------------------------
  localparam int POS_TMR2   = 12;         // Timer channel 2 level
  localparam int POS_TMR3   = 8;          // Timer channel 3 level
  localparam int POS_TMR4   = 4;          // Timer channel 4 level
  localparam int POS_SER0   = 0;          // Serial channel 0 level
  localparam int POS_SER1   = 12;         // Serial channel 1 level
  localparam int POS_PAR_AD = 8;          // Parity and converter level
  localparam int POS_WD_REF = 4;          // Watchdog and refresh level
  localparam int POS_NMI_LVL  = 15;       // Pin level, read-only
  localparam int POS_NMI_EDGE = 8;        // Pin edge polarity

  // Writable bits of the second-serial register, low nibble reserved
  localparam logic [15:0] SER_2ND_MASK = 16'hfff0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PRIO      = 16'h0000; // Both priority regs
  localparam logic        RST_NMI_EDGE  = 1'b0;     // Falling edge
  localparam logic [7:0]  RST_SENSE     = 8'h00;    // All level sense
  localparam logic        RST_PIN_IDLE  = 1'b1;     // Pin sync idle value

  // ----------------------------------------------------------------
  // Arbitrated source indices
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_TMR2    = 4'h0; // Timer channel 2
  localparam logic [3:0] SRC_TMR3    = 4'h1; // Timer channel 3
  localparam logic [3:0] SRC_TMR4    = 4'h2; // Timer channel 4
  localparam logic [3:0] SRC_SER0    = 4'h3; // Serial channel 0
  localparam logic [3:0] SRC_SER1    = 4'h4; // Serial channel 1
  localparam logic [3:0] SRC_PARITY  = 4'h5; // Bus parity check
  localparam logic [3:0] SRC_ADC     = 4'h6; // Converter
  localparam logic [3:0] SRC_WDOG    = 4'h7; // Watchdog timer
  localparam logic [3:0] SRC_REFRESH = 4'h8; // Memory refresh control

endpackage

/* src/ipsc_top.sv */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps

module ipsc_top
(
  input  wire logic        clock,        // System clock, 25 MHz
  input  wire logic        rst_n,        // Async reset, active low
  // Register port
  input  wire logic [27:0] addr,         // Byte address
  input  wire logic [15:0] wdata,        // Write data
  input  wire logic        wr,           // Write strobe
  input  wire logic        rd,           // Read strobe
  output logic      [15:0] rdata,        // Read data, cycle after rd
  // Pins
  input  wire logic        nmi_pin,      // Non-maskable request pin
  input  wire logic [7:0]  ext_req_pin,  // External requests, input 0 msb
  input  wire logic [7:0]  ext_ack,      // Clears latched edge requests
  // On-chip sources, same clock
  input  wire logic [8:0]  src_req,      // Source request levels
  input  wire logic [3:0]  cpu_mask,     // Processor mask level
  // Requests to the core
  output logic             nmi_req,      // One-cycle pin edge pulse
  output logic      [7:0]  ext_req,      // Sensed external requests
  output logic             arb_valid,    // A source beats the mask
  output logic      [3:0]  arb_level,    // Winning level
  output logic      [3:0]  arb_src       // Winning source index
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [15:0] prio_tmr_ser;   // Timer/serial priority register
    logic [15:0] prio_ser_2nd;   // Second-serial priority register
    logic        nmi_edge_pol;   // One selects rising edge
    logic [7:0]  sense_sel;      // Bit 7 input 0 .. bit 0 input 7
    logic        nmi_s1;         // Pin sync stage one
    logic        nmi_s2;         // Pin sync stage two
    logic        nmi_prev;       // Previous synced pin
    logic [7:0]  ext_s1;         // Input sync stage one
    logic [7:0]  ext_s2;         // Input sync stage two
    logic [7:0]  ext_prev;       // Previous synced inputs
    logic [7:0]  ext_pend;       // Latched falling edges
    logic [15:0] rdata;          // Read data register
    logic        nmi_req;        // Edge pulse
    logic [7:0]  ext_req;        // Sensed requests
    logic        arb_valid;      // Winner present
    logic [3:0]  arb_level;      // Winning level
    logic [3:0]  arb_src;        // Winning source
  } ipsc_state_t;

  ipsc_state_t state;            // Registered state
  ipsc_state_t next_state;       // Next state

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pull one 4-bit priority field out of a register
  function automatic logic [3:0] get_field
  (
    input logic [15:0] value,
    input int          pos
  );
    get_field = value[pos +: 4];
  endfunction

  // Level assigned to each arbitrated source
  function automatic logic [3:0] src_level
  (
    input logic [15:0] tmr_ser,
    input logic [15:0] ser_2nd,
    input int          idx
  );
    logic [3:0] lvl;
    lvl = 4'h0;
    unique case (idx)
      0: lvl = get_field(tmr_ser, ipsc_pkg::POS_TMR2);
      1: lvl = get_field(tmr_ser, ipsc_pkg::POS_TMR3);
      2: lvl = get_field(tmr_ser, ipsc_pkg::POS_TMR4);
      3: lvl = get_field(tmr_ser, ipsc_pkg::POS_SER0);
      4: lvl = get_field(ser_2nd, ipsc_pkg::POS_SER1);
      5: lvl = get_field(ser_2nd, ipsc_pkg::POS_PAR_AD);
      6: lvl = get_field(ser_2nd, ipsc_pkg::POS_PAR_AD);
      7: lvl = get_field(ser_2nd, ipsc_pkg::POS_WD_REF);
      8: lvl = get_field(ser_2nd, ipsc_pkg::POS_WD_REF);
      default: lvl = 4'h0;
    endcase
    src_level = lvl;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Register access, pin sensing and arbitration
  always_comb
  begin
    logic        nmi_rise;       // Synced pin rose
    logic        nmi_fall;       // Synced pin fell
    logic [7:0]  ext_fall;       // Synced inputs fell
    logic [3:0]  best_lvl;       // Running best level
    logic [3:0]  best_src;       // Running best source
    logic        best_ok;        // Running winner flag
    logic [3:0]  lvl;            // Level under test
    logic [15:0] sense_word;     // Sense register image
    nmi_rise   = 1'b0;
    nmi_fall   = 1'b0;
    ext_fall   = 8'h00;
    best_lvl   = 4'h0;
    best_src   = 4'h0;
    best_ok    = 1'b0;
    lvl        = 4'h0;
    sense_word = 16'h0000;
    next_state = state;

    // Synchronise pins, first stage only feeds the second
    next_state.nmi_s1   = nmi_pin;
    next_state.nmi_s2   = state.nmi_s1;
    next_state.nmi_prev = state.nmi_s2;
    next_state.ext_s1   = ext_req_pin;
    next_state.ext_s2   = state.ext_s1;
    next_state.ext_prev = state.ext_s2;

    // Register writes
    if (wr)
    begin
      unique case (addr)
        ipsc_pkg::OFS_PRIO_TMR_SER:
        begin
          next_state.prio_tmr_ser = wdata;
        end
        ipsc_pkg::OFS_PRIO_SER_2ND:
        begin
          // Low nibble is reserved and stays zero
          next_state.prio_ser_2nd =
            wdata & ipsc_pkg::SER_2ND_MASK;
        end
        ipsc_pkg::OFS_SENSE_CTRL:
        begin
          // Pin level bit ignores writes
          next_state.nmi_edge_pol =
            wdata[ipsc_pkg::POS_NMI_EDGE];
          next_state.sense_sel = wdata[7:0];
        end
        default:
        begin
          // Unmapped write is dropped
        end
      endcase
    end

    // Sense register image, pin level from the synced pin
    sense_word[ipsc_pkg::POS_NMI_LVL]  = state.nmi_s2;
    sense_word[ipsc_pkg::POS_NMI_EDGE] = state.nmi_edge_pol;
    sense_word[7:0]                    = state.sense_sel;

    // Register reads, data stands one cycle only
    next_state.rdata = 16'h0000;
    if (rd)
    begin
      unique case (addr)
        ipsc_pkg::OFS_PRIO_TMR_SER:
        begin
          next_state.rdata = state.prio_tmr_ser;
        end
        ipsc_pkg::OFS_PRIO_SER_2ND:
        begin
          next_state.rdata = state.prio_ser_2nd;
        end
        ipsc_pkg::OFS_SENSE_CTRL:
        begin
          next_state.rdata = sense_word;
        end
        default:
        begin
          // Unmapped read returns zero
          next_state.rdata = 16'h0000;
        end
      endcase
    end

    // Pin edge detection on synced samples
    nmi_rise = state.nmi_s2 & ~state.nmi_prev;
    nmi_fall = ~state.nmi_s2 & state.nmi_prev;
    if (state.nmi_edge_pol)
    begin
      next_state.nmi_req = nmi_rise;
    end
    else
    begin
      next_state.nmi_req = nmi_fall;
    end

    // External inputs: level or latched falling edge
    ext_fall = ~state.ext_s2 & state.ext_prev;
    for (int i = 0; i < ipsc_pkg::NUM_EXT; i++)
    begin
      // Input i uses sense bit 7-i
      if (state.sense_sel[7 - i])
      begin
        // Edge set wins over a same-cycle acknowledge
        if (ext_fall[7 - i])
        begin
          next_state.ext_pend[7 - i] = 1'b1;
        end
        else if (ext_ack[7 - i])
        begin
          next_state.ext_pend[7 - i] = 1'b0;
        end
        next_state.ext_req[7 - i] = next_state.ext_pend[7 - i];
      end
      else
      begin
        // Level mode drops any stale latched edge
        next_state.ext_pend[7 - i] = 1'b0;
        next_state.ext_req[7 - i]  = ~state.ext_s2[7 - i];
      end
    end

    // Arbitration: highest level above the mask, low index on ties
    for (int s = 0; s < ipsc_pkg::NUM_SRC; s++)
    begin
      lvl = src_level(state.prio_tmr_ser, state.prio_ser_2nd, s);
      if (src_req[s] && (lvl > cpu_mask) &&
          (!best_ok || (lvl > best_lvl)))
      begin
        best_ok  = 1'b1;
        best_lvl = lvl;
        best_src = s[3:0];
      end
    end
    next_state.arb_valid = best_ok;
    next_state.arb_level = best_lvl;
    next_state.arb_src   = best_src;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Constant reset values, every register on every edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state.prio_tmr_ser <= ipsc_pkg::RST_PRIO;
      state.prio_ser_2nd <= ipsc_pkg::RST_PRIO;
      state.nmi_edge_pol <= ipsc_pkg::RST_NMI_EDGE;
      state.sense_sel    <= ipsc_pkg::RST_SENSE;
      state.nmi_s1       <= ipsc_pkg::RST_PIN_IDLE;
      state.nmi_s2       <= ipsc_pkg::RST_PIN_IDLE;
      state.nmi_prev     <= ipsc_pkg::RST_PIN_IDLE;
      state.ext_s1       <= {8{ipsc_pkg::RST_PIN_IDLE}};
      state.ext_s2       <= {8{ipsc_pkg::RST_PIN_IDLE}};
      state.ext_prev     <= {8{ipsc_pkg::RST_PIN_IDLE}};
      state.ext_pend     <= 8'h00;
      state.rdata        <= 16'h0000;
      state.nmi_req      <= 1'b0;
      state.ext_req      <= 8'h00;
      state.arb_valid    <= 1'b0;
      state.arb_level    <= 4'h0;
      state.arb_src      <= 4'h0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from flip-flops
  // ----------------------------------------------------------------
  assign rdata     = state.rdata;
  assign nmi_req   = state.nmi_req;
  assign ext_req   = state.ext_req;
  assign arb_valid = state.arb_valid;
  assign arb_level = state.arb_level;
  assign arb_src   = state.arb_src;

endmodule // ipsc_top

/* tb/ipsc_src_model.sv */
`timescale 1ns/100ps
// -----------------------------
// On-chip sources and core side
// -----------------------------
module ipsc_src_model
(
  input  wire logic       clock,   // Clock
  input  wire logic [8:0] fire,    // Sources to raise
  input  wire logic       ack_en,  // Core takes edge requests
  input  wire logic [7:0] ext_req, // Sensed requests
  output logic      [8:0] src_req, // Levels, bit 8 memory refresh
  output logic      [7:0] ext_ack  // Acks to latched requests
);
  initial src_req = 9'h000;
  initial ext_ack = 8'h00;
  // Sources hold their level, core acks what it sees
  always @(posedge clock)
  begin
    src_req <= fire;
    ext_ack <= ext_req & {8{ack_en}};
  end
endmodule // ipsc_src_model

/* tb/ipsc_sva.sv */
`timescale 1ns/100ps
// --------------------------------
// Port checker for the sense block
// --------------------------------
module ipsc_sva
(
  input wire logic        clock,       // Clock
  input wire logic        rst_n,       // Reset
  input wire logic [27:0] addr,        // Address
  input wire logic [15:0] wdata,       // Write data
  input wire logic        wr,          // Write strobe
  input wire logic        rd,          // Read strobe
  input wire logic [15:0] rdata,       // Read data
  input wire logic        nmi_pin,     // Pin
  input wire logic [7:0]  ext_req_pin, // Request pins
  input wire logic [7:0]  ext_ack,     // Acks
  input wire logic [8:0]  src_req,     // Sources
  input wire logic [3:0]  cpu_mask,    // Mask
  input wire logic        nmi_req,     // Pin pulse
  input wire logic [7:0]  ext_req,     // Requests
  input wire logic        arb_valid,   // Winner valid
  input wire logic [3:0]  arb_level,   // Winner level
  input wire logic [3:0]  arb_src      // Winner index
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic       pol;    // Edge polarity shadow
  logic [7:0] sns;    // Sense shadow
  logic [8:0] src_d;  // Sources one cycle back
  logic [3:0] msk_d;  // Mask one cycle back
  // Shadows follow writes, inputs delayed one cycle
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      pol   <= 1'b0;
      sns   <= 8'h00;
      src_d <= 9'h000;
      msk_d <= 4'h0;
    end
    else
    begin
      src_d <= src_req;
      msk_d <= cpu_mask;
      if (wr && addr == ipsc_pkg::OFS_SENSE_CTRL)
      begin
        pol <= wdata[8];
        sns <= wdata[7:0];
      end
    end
  sequence s_tmr_wr_rd;
    wr && addr == ipsc_pkg::OFS_PRIO_TMR_SER ##1
    rd && addr == ipsc_pkg::OFS_PRIO_TMR_SER;
  endsequence
  sequence s_ser_wr_rd;
    wr && addr == ipsc_pkg::OFS_PRIO_SER_2ND ##1
    rd && addr == ipsc_pkg::OFS_PRIO_SER_2ND;
  endsequence
  sequence s_pin_edge;
    (nmi_pin != pol) ##1 (nmi_pin == pol);
  endsequence
  AST_TMR_RW: assert property (
    s_tmr_wr_rd |=> rdata == $past(wdata, 2))
    else $error("timer word readback wrong");
  AST_SER_RW: assert property (
    s_ser_wr_rd |=> rdata == ($past(wdata, 2) & 16'hfff0))
    else $error("second serial readback wrong");
  AST_SNS_RD: assert property (
    rd && addr == ipsc_pkg::OFS_SENSE_CTRL |=>
    rdata[14:0] == {6'h00, pol, sns})
    else $error("sense word readback wrong");
  AST_NMI_LVL: assert property (
    $stable(nmi_pin)[*4] ##0 (rd && addr == ipsc_pkg::OFS_SENSE_CTRL)
    |=> rdata[15] == $past(nmi_pin))
    else $error("pin level bit wrong");
  // Two sync stages and the output flop: pulse seen three edges on
  AST_NMI_FIRE: assert property (
    s_pin_edge |-> ##3 nmi_req)
    else $error("pin edge missed");
  AST_NMI_ONLY: assert property (
    nmi_req |-> $past(nmi_pin, 3) == pol && $past(nmi_pin, 4) != pol)
    else $error("pulse without selected edge");
  // Level request trails the pin by three sampled edges
  AST_EXT_LVL: assert property (
    $stable(sns)[*3] |->
    ((ext_req ^ ~$past(ext_req_pin, 3)) & ~sns) == 8'h00)
    else $error("level request does not follow pin");
  AST_EXT_EDGE: assert property (
    ((ext_req & ~$past(ext_req)) & $past(sns) &
     ~($past(ext_req_pin, 4) & ~$past(ext_req_pin, 3))) == 8'h00)
    else $error("edge request without falling edge");
  AST_ARB_MASK: assert property (
    arb_valid |-> arb_level > msk_d && src_d[arb_src])
    else $error("winner not above mask or idle");
endmodule // ipsc_sva

bind ipsc_top ipsc_sva ipsc_sva_inst (.*);

/* tb/tb_irq_priority_and_sense_control.sv */
`timescale 1ns/100ps
module tb_irq_priority_and_sense_control;
  // -------------
  // Bench signals
  // -------------
  localparam logic [27:0] A_T = ipsc_pkg::OFS_PRIO_TMR_SER; // Timer word
  localparam logic [27:0] A_S = ipsc_pkg::OFS_PRIO_SER_2ND; // Serial word
  localparam logic [27:0] A_C = ipsc_pkg::OFS_SENSE_CTRL;   // Sense word
  logic        clock = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        rd_d = 1'b0, nmi_pin = 1'b1, ack_en = 1'b0;
  logic        nmi_req, arb_valid;         // Outputs
  logic [27:0] addr = 28'h0;               // Address
  logic [15:0] wdata = 16'h0, rdata, tv, sv, cv, e; // Data, shadows
  logic [7:0]  ext_req_pin = 8'hff, ext_req, ext_ack;
  logic [8:0]  fire = 9'h0, src_req;       // Source commands
  logic [3:0]  cpu_mask = 4'h0, arb_level, arb_src, m, lv;
  logic [31:0] seed = 32'd44;              // Xorshift state
  logic [15:0] exp_q[$];                   // Expected read data
  int          fail_count = 0, check_count = 0, pulses = 0;
  ipsc_top ipsc_top_inst (.*);
  ipsc_src_model ipsc_src_model_inst (.*);
  always #20 clock = ~clock;
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [3:0] lvl(int i);
    case (i)
      0: return tv[15:12];
      1: return tv[11:8];
      2: return tv[7:4];
      3: return tv[3:0];
      4: return sv[15:12];
      5, 6: return sv[11:8];
      default: return sv[7:4];
    endcase
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle, strobes held for one clock
  task automatic bus(logic w, logic r, logic [27:0] a, logic [15:0] d,
                     logic [15:0] x);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    if (r)
      exp_q.push_back(x);
    @(posedge clock);
  endtask
  // Move the pin, count pulses
  task automatic pin(logic p, int n);
    pulses = 0;
    nmi_pin <= p;
    repeat (6) @(posedge clock);
    chk(16'(pulses), 16'(n));
  endtask
  task automatic look(logic [15:0] got, logic [15:0] exp);
    @(negedge clock);
    chk(got, exp);
    @(posedge clock);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Read monitor takes the oldest note
  always @(posedge clock) rd_d <= rd;
  always @(negedge clock)
  begin
    if (rd_d)
      chk(rdata, exp_q.pop_front());
    if (nmi_req === 1'b1)
      pulses++;
  end
  // Watchdog
  initial
  begin
    #100000;
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    bus(0, 1, A_T, 0, 16'h0000);
    bus(0, 1, A_S, 0, 16'h0000);
    bus(0, 1, A_C, 0, 16'h8000);
    bus(1, 0, A_C + 28'h2, 16'hffff, 0);
    bus(0, 1, A_C + 28'h2, 0, 16'h0000);
    repeat (8)
    begin
      tv = rnd();
      sv = rnd();
      cv = rnd() & 16'hfeff;
      bus(1, 0, A_T, tv, 0);
      bus(0, 1, A_T, 0, tv);
      bus(1, 0, A_S, sv, 0);
      bus(0, 1, A_S, 0, sv & 16'hfff0);
      bus(1, 0, A_C, cv, 0);
      bus(0, 1, A_C, 0, {8'h80, cv[7:0]});
    end
    bus(1, 0, A_C, 16'h0000, 0);
    for (int i = 0; i < 9; i++)
      for (int k = 0; k < 3; k++)
      begin
        lv = lvl(i);
        m = (k == 0) ? 4'(rnd()) : (k == 1) ? lv : lv - 4'h1;
        e = (lv > m) ? {8'h01, lv, 4'(i)} : 16'h0000;
        fire <= 9'h001 << i;
        cpu_mask <= m;
        bus(0, 0, A_T, 0, 0);
        repeat (3) @(posedge clock);
        look({7'h00, arb_valid, arb_level, arb_src}, e);
      end
    e = 16'h0000;
    for (int i = 8; i >= 0; i--)
      if (lvl(i) != 4'h0 && lvl(i) >= e[7:4])
        e = {8'h01, lvl(i), 4'(i)};
    fire <= 9'h1ff;
    cpu_mask <= 4'h0;
    repeat (4) @(posedge clock);
    look({7'h00, arb_valid, arb_level, arb_src}, e);
    pin(1'b0, 1);
    bus(0, 1, A_C, 0, 16'h0000);
    bus(0, 0, A_C, 0, 0);
    pin(1'b1, 0);
    pin(1'b0, 1);
    bus(1, 0, A_C, 16'h0100, 0);
    bus(0, 0, A_C, 0, 0);
    pin(1'b1, 1);
    pin(1'b0, 0);
    pin(1'b1, 1);
    bus(1, 0, A_C, 16'h0000, 0);
    bus(0, 0, A_C, 0, 0);
    ext_req_pin <= 8'h7e;
    repeat (5) @(posedge clock);
    look({8'h00, ext_req}, 16'h0081);
    ext_req_pin <= 8'hff;
    repeat (5) @(posedge clock);
    look({8'h00, ext_req}, 16'h0000);
    bus(1, 0, A_C, 16'h00ff, 0);
    bus(0, 0, A_C, 0, 0);
    ext_req_pin <= 8'h00;
    repeat (5) @(posedge clock);
    ext_req_pin <= 8'hff;
    repeat (5) @(posedge clock);
    look({8'h00, ext_req}, 16'h00ff);
    ack_en <= 1'b1;
    repeat (3) @(posedge clock);
    look({8'h00, ext_req}, 16'h0000);
    ack_en <= 1'b0;
    bus(0, 1, A_C, 0, 16'h80ff);
    bus(0, 0, A_C, 0, 0);
    repeat (3) @(posedge clock);
    wrap_up();
  end
endmodule // tb_irq_priority_and_sense_control
